/* dv/ieb_engine_model.sv */
// Packet engine stand-in: accepts decisions, can stall.
// Assumes the decision port of ieb_top on the same clock.
`default_nettype none
module ieb_engine_model (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        stall_in,
  input  wire logic        rsp_valid_in,
  input  wire logic [27:0] rsp_bits_in,
  output logic             rsp_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [27:0] got[$];
  // Collect accepted answers; ready is the inverse of stall, one edge late
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_ready_out <= 1'b0;
    end else begin
      if (rsp_valid_in && rsp_ready_out) got.push_back(rsp_bits_in);
      rsp_ready_out <= !stall_in;
    end
  end
endmodule
`default_nettype wire

/* dv/usb_in_endpoint_buffer_descriptors_tb_top.sv */
// Bench for ieb_top: AHB-Lite tasks, requests, completions.
// Assumes one clock; engine model answers or stalls.
`default_nettype none
module usb_in_endpoint_buffer_descriptors_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst_n, hsel, hwrite, hready, hresp, stall;
  logic        req_valid, req_y, req_ready, done_valid, done_y;
  logic        rsp_valid, rsp_ready, rsp_nak, rsp_y;
  logic [2:0]  req_ep, done_ep, rsp_ep;
  logic [1:0]  htrans;
  logic [10:0] rsp_addr;
  logic [11:0] rsp_len;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          fail_count, checks_done;

  ieb_top ieb_top_inst (.mclk_in(mclk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hrdata_out(hrdata), .hresp_out(hresp), .req_valid_in(req_valid),
    .req_ep_in(req_ep), .req_y_in(req_y), .req_ready_out(req_ready), .done_valid_in(done_valid),
    .done_ep_in(done_ep), .done_y_in(done_y), .rsp_valid_out(rsp_valid), .rsp_ready_in(rsp_ready),
    .rsp_nak_out(rsp_nak), .rsp_ep_out(rsp_ep), .rsp_y_out(rsp_y), .rsp_addr_out(rsp_addr),
    .rsp_len_out(rsp_len));
  ieb_engine_model ieb_engine_model_inst (.mclk_in(mclk), .rst_n_in(rst_n), .stall_in(stall),
    .rsp_valid_in(rsp_valid), .rsp_bits_in({rsp_nak, rsp_ep, rsp_y, rsp_addr, rsp_len}),
    .rsp_ready_out(rsp_ready));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic report_and_stop;
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Ends the run when a bounded wait ran out
  task automatic hang(input logic ok);
    if (ok !== 1'b1) begin
      check(32'h0000_0000, 32'h0000_0001);
      report_and_stop();
    end
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hang(hready);
  endtask

  // One AHB-Lite single word transfer
  task automatic ahb(input logic w, input logic [11:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= ieb_pkg::HTRANS_IDLE;
    hwdata <= {24'h00_0000, d};
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 8'h00);
    check(rd, exp);
  endtask

  // Decision request; held until taken
  task automatic req(input logic [2:0] ep, input logic y, input logic last);
    int n;
    n         = 0;
    req_valid <= 1'b1;
    req_ep    <= ep;
    req_y     <= y;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    hang(req_ready);
    if (last) req_valid <= 1'b0;
  endtask

  task automatic done(input logic [2:0] ep, input logic y);
    done_valid <= 1'b1;
    done_ep    <= ep;
    done_y     <= y;
    @(posedge mclk);
    done_valid <= 1'b0;
  endtask

  function automatic logic [27:0] pk(input logic k, input logic [2:0] e, input logic y,
                                     input logic [10:0] a, input logic [11:0] l);
    return {k, e, y, a, l};
  endfunction

  task automatic expect_rsp(input logic [27:0] exp);
    int n;
    n = 0;
    while (ieb_engine_model_inst.got.size() == 0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    hang(ieb_engine_model_inst.got.size() != 0);
    check({4'h0, ieb_engine_model_inst.got.pop_front()}, {4'h0, exp});
  endtask

  // Global watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    hang(1'b0);
  end

  // Main sequence
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, stall} = '0;
    {req_valid, req_ep, req_y, done_valid, done_ep, done_y} = '0;
    fail_count  = 0;
    checks_done = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rdc(12'h01C, 32'h0000_0000);
    wr(12'h0DC, 8'h3C);
    rdc(12'h0DC, 32'h0000_003C);
    wr(12'h0E0, 8'h55);
    rdc(12'h0E0, 32'h0000_0000);
    wr(12'h014, 8'hA5);
    wr(12'h01C, 8'h0A);
    req(3'h0, 1'b1, 1'b1);
    expect_rsp(pk(1'b0, 3'h0, 1'b1, 11'h528, 12'h00A));
    done(3'h0, 1'b1);
    rdc(12'h01C, 32'h0000_008A);
    req(3'h0, 1'b1, 1'b1);
    expect_rsp(pk(1'b1, 3'h0, 1'b1, 11'h528, 12'h000));
    wr(12'h00C, 8'h05);
    done(3'h0, 1'b0);
    rdc(12'h00C, 32'h0000_0085);
    req(3'h0, 1'b0, 1'b1);
    expect_rsp(pk(1'b1, 3'h0, 1'b0, 11'h000, 12'h000));
    wr(12'h00C, 8'h05);
    req(3'h0, 1'b0, 1'b1);
    expect_rsp(pk(1'b0, 3'h0, 1'b0, 11'h000, 12'h005));
    // Isochronous endpoint, largest sample size, flag left set
    wr(12'h020, 8'h5F);
    wr(12'h034, 8'h10);
    wr(12'h03C, 8'hFF);
    req(3'h1, 1'b1, 1'b1);
    expect_rsp(pk(1'b0, 3'h1, 1'b1, 11'h080, 12'hFE0));
    wr(12'h020, 8'h1F);
    req(3'h1, 1'b1, 1'b1);
    expect_rsp(pk(1'b1, 3'h1, 1'b1, 11'h080, 12'h000));
    wr(12'h03C, 8'h7F);
    req(3'h1, 1'b1, 1'b1);
    expect_rsp(pk(1'b0, 3'h1, 1'b1, 11'h080, 12'h07F));
    wr(12'h020, 8'h40);
    wr(12'h02C, 8'h83);
    req(3'h1, 1'b0, 1'b1);
    expect_rsp(pk(1'b0, 3'h1, 1'b0, 11'h000, 12'h003));
    wr(12'h02C, 8'h03);
    // Engine stalls: two answers held, third request refused
    stall <= 1'b1;
    @(posedge mclk);
    req(3'h1, 1'b0, 1'b0);
    req(3'h1, 1'b0, 1'b1);
    @(posedge mclk);
    check({31'h0, req_ready}, 32'h0000_0000);
    check(32'(ieb_engine_model_inst.got.size()), 32'h0000_0000);
    stall <= 1'b0;
    req(3'h1, 1'b0, 1'b1);
    repeat (3) expect_rsp(pk(1'b0, 3'h1, 1'b0, 11'h000, 12'h003));
    report_and_stop();
  end
endmodule
`default_nettype wire

/* rtl/ieb_pkg.sv */
// Constants for the IN endpoint descriptor block.
// Assumes one system clock and an AHB-Lite register bus.
// Behaviour
// - Eight descriptor bytes each, seven endpoints
// - Y send done sets Y empty flag
// - X send done sets X empty flag
// - Empty flag set: answer NAK, non-iso
// - Isochronous never NAKs, flag ignored
// - Count is bytes, or iso samples
// - Start address is base byte, three zeros
// - Sample size code n means n+1 bytes
// - Config iso bit selects isochronous
`default_nettype none
package ieb_pkg;
  localparam int         NUM_EP      = 7;
  localparam int         DESC_BYTES  = 8;
  localparam int         NUM_BYTES   = NUM_EP * DESC_BYTES;
  // Byte index inside one descriptor block; EP_NONE is the unused endpoint number
  localparam logic [2:0] IDX_CFG     = 3'h0;
  localparam logic [2:0] IDX_X_BASE  = 3'h1;
  localparam logic [2:0] IDX_BSIZE   = 3'h2;
  localparam logic [2:0] IDX_X_COUNT = 3'h3;
  localparam logic [2:0] IDX_Y_BASE  = 3'h5;
  localparam logic [2:0] IDX_Y_COUNT = 3'h7;
  localparam logic [2:0] EP_NONE     = 3'h7;
  // Field positions
  localparam int         FLAG_BIT    = 7;
  localparam int         ISO_BIT     = 6;
  localparam int         BASE_LSB    = 3;
  // Bus decode
  localparam int         SLOT_LSB    = 2;
  localparam int         SLOT_MSB    = 7;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  // Reset values
  localparam logic [7:0] DESC_RESET  = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  // Answer layout
  localparam int         ADDR_W      = 11;
  localparam int         LEN_W       = 12;
  localparam int         RSP_W       = 1 + 3 + 1 + ADDR_W + LEN_W;
endpackage
`default_nettype wire

/* rtl/ieb_skid.sv */
// Two-entry buffer between the descriptor decision and the packet engine.
// Assumes both sides on the same clock; all outputs come from flops.
`default_nettype none
module ieb_skid #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  logic             skid_valid, next_skid_valid;
  logic [WIDTH-1:0] skid_data, next_skid_data;
  logic             next_out_valid, next_in_ready;
  logic [WIDTH-1:0] next_out_data;
  logic             push;

  // Output stage drains first, second entry catches a stalled push
  always_comb begin
    push            = in_valid_in & in_ready_out;
    next_out_valid  = out_valid_out;
    next_out_data   = out_data_out;
    next_skid_valid = skid_valid;
    next_skid_data  = skid_data;
    if (!out_valid_out || out_ready_in) begin
      if (skid_valid) begin
        next_out_valid  = 1'b1;
        next_out_data   = skid_data;
        next_skid_valid = 1'b0;
      end else begin
        next_out_valid = push;
        next_out_data  = in_data_in;
      end
    end else if (push) begin
      next_skid_valid = 1'b1;
      next_skid_data  = in_data_in;
    end
    next_in_ready = ~next_skid_valid;
  end

  // State registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
      skid_valid    <= 1'b0;
      skid_data     <= '0;
      in_ready_out  <= 1'b1;
    end else begin
      out_valid_out <= next_out_valid;
      out_data_out  <= next_out_data;
      skid_valid    <= next_skid_valid;
      skid_data     <= next_skid_data;
      in_ready_out  <= next_in_ready;
    end
  end
endmodule
`default_nettype wire

/* rtl/ieb_top.sv */
// IN endpoint descriptor bytes, empty flags and send/NAK decision.
// Assumes AHB-Lite master and packet engine on mclk_in.
`default_nettype none
module ieb_top (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic [31:0]      hrdata_out,
  output logic             hresp_out,
  // IN token request from the packet engine
  input  wire logic        req_valid_in,
  input  wire logic [2:0]  req_ep_in,
  input  wire logic        req_y_in,
  output logic             req_ready_out,
  // Successful IN transaction completed
  input  wire logic        done_valid_in,
  input  wire logic [2:0]  done_ep_in,
  input  wire logic        done_y_in,
  // Decision towards the packet engine
  output logic             rsp_valid_out,
  input  wire logic        rsp_ready_in,
  output logic             rsp_nak_out,
  output logic [2:0]       rsp_ep_out,
  output logic             rsp_y_out,
  output logic [10:0]      rsp_addr_out,
  output logic [11:0]      rsp_len_out
);
  typedef enum logic [1:0] {
    IEB_IDLE  = 2'b01,
    IEB_WDATA = 2'b10
  } ieb_bus_t;

  // Descriptor slot from endpoint and byte index
  function automatic logic [5:0] slot_of(
    input logic [2:0] ep,
    input logic [2:0] idx
  );
    return {ep, idx};
  endfunction

  // Packet length in bytes
  function automatic logic [11:0] pkt_len(
    input logic [6:0] cnt,
    input logic       iso,
    input logic [4:0] bytes_per_sample
  );
    logic [5:0] size;
    size = {1'b0, bytes_per_sample} + 6'h01;
    if (iso) begin
      return {5'h00, cnt} * {6'h00, size};
    end
    return {5'h00, cnt};
  endfunction

  logic [7:0]  desc      [ieb_pkg::NUM_BYTES];
  logic [7:0]  next_desc [ieb_pkg::NUM_BYTES];
  ieb_bus_t    state, next_state;
  logic [5:0]  wr_slot, next_wr_slot;
  logic [31:0] next_hrdata;
  logic        take, addr_ok, wr_take;
  logic [5:0]  bus_slot, done_slot;
  logic        done_ok;

  // Address phase decode
  always_comb begin
    take     = hsel_in & hready_in & htrans_in[1];
    bus_slot = haddr_in[ieb_pkg::SLOT_MSB:ieb_pkg::SLOT_LSB];
    addr_ok  = (haddr_in[31:8] == 24'h00_0000) &&
               (haddr_in[1:0] == 2'h0) &&
               (haddr_in[7:5] != ieb_pkg::EP_NONE);
    wr_take  = take & hwrite_in & addr_ok;
  end

  // Bus phase tracking
  always_comb begin
    next_wr_slot = wr_take ? bus_slot : wr_slot;
    case (state)
      IEB_IDLE, IEB_WDATA: begin
        next_state = wr_take ? IEB_WDATA : IEB_IDLE;
      end
      default: begin
        next_state = IEB_IDLE;
      end
    endcase
  end

  // Completion slot: flag lives in the count byte
  always_comb begin
    done_ok   = done_valid_in && (done_ep_in != ieb_pkg::EP_NONE);
    done_slot = slot_of(done_ep_in,
                        done_y_in ? ieb_pkg::IDX_Y_COUNT : ieb_pkg::IDX_X_COUNT);
  end

  // Descriptor next values; hardware set beats software clear
  always_comb begin
    next_desc = desc;
    if (state == IEB_WDATA) begin
      next_desc[wr_slot] = hwdata_in[7:0];
    end
    if (done_ok) begin
      next_desc[done_slot][ieb_pkg::FLAG_BIT] = 1'b1;
    end
  end

  // Read data, forwarded from the pending write
  always_comb begin
    next_hrdata = ieb_pkg::RDATA_RESET;
    if (take && !hwrite_in && addr_ok) begin
      next_hrdata = {24'h00_0000, next_desc[bus_slot]};
    end
  end

  // Bus and descriptor registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state         <= IEB_IDLE;
      wr_slot       <= 6'h00;
      hrdata_out    <= ieb_pkg::RDATA_RESET;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      for (int i = 0; i < ieb_pkg::NUM_BYTES; i++) begin
        desc[i] <= ieb_pkg::DESC_RESET;
      end
    end else begin
      state         <= next_state;
      wr_slot       <= next_wr_slot;
      hrdata_out    <= next_hrdata;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      for (int i = 0; i < ieb_pkg::NUM_BYTES; i++) begin
        desc[i] <= next_desc[i];
      end
    end
  end

  // Send or NAK decision for the requested buffer
  logic [7:0]  cfg, cnt, base;
  logic        iso, ep_bad, nak;
  logic [4:0]  bytes_per_sample;
  logic [10:0] start;
  logic [11:0] len;
  logic [ieb_pkg::RSP_W-1:0] rsp_in, rsp_q;

  always_comb begin
    cfg    = desc[slot_of(req_ep_in, ieb_pkg::IDX_CFG)];
    cnt    = desc[slot_of(req_ep_in,
                 req_y_in ? ieb_pkg::IDX_Y_COUNT : ieb_pkg::IDX_X_COUNT)];
    base   = desc[slot_of(req_ep_in,
                 req_y_in ? ieb_pkg::IDX_Y_BASE : ieb_pkg::IDX_X_BASE)];
    iso    = cfg[ieb_pkg::ISO_BIT];
    bytes_per_sample    = cfg[4:0];
    ep_bad = (req_ep_in == ieb_pkg::EP_NONE);
    nak    = ep_bad || (!iso && cnt[ieb_pkg::FLAG_BIT]);
    start  = ep_bad ? 11'h000 : {base, 3'h0};
    len    = nak ? 12'h000 : pkt_len(cnt[6:0], iso, bytes_per_sample);
    rsp_in = {nak, req_ep_in, req_y_in, start, len};
  end

  // Two-entry buffer so a stalled engine loses no decision
  ieb_skid #(
    .WIDTH(ieb_pkg::RSP_W)
  ) u_skid (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .in_valid_in  (req_valid_in),
    .in_data_in   (rsp_in),
    .in_ready_out (req_ready_out),
    .out_valid_out(rsp_valid_out),
    .out_ready_in (rsp_ready_in),
    .out_data_out (rsp_q)
  );

  // Answer fields, straight from the buffer flops
  assign rsp_nak_out  = rsp_q[27];
  assign rsp_ep_out   = rsp_q[26:24];
  assign rsp_y_out    = rsp_q[23];
  assign rsp_addr_out = rsp_q[22:12];
  assign rsp_len_out  = rsp_q[11:0];

  // Checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_fire_empty;
    req_valid_in && req_ready_out && !rsp_valid_out;
  endsequence

  sequence s_fire_bulk;
    s_fire_empty ##0 (!ep_bad && !iso);
  endsequence

  sequence s_fire_iso;
    s_fire_empty ##0 (!ep_bad && iso);
  endsequence

  sequence s_stall;
    rsp_valid_out && !rsp_ready_in;
  endsequence

  y_flag_set_a: assert property (
    done_ok && done_y_in |=> desc[$past(done_slot)][ieb_pkg::FLAG_BIT])
    else $error("Y empty flag not set after completion");

  x_flag_set_a: assert property (
    done_ok && !done_y_in |=> desc[$past(done_slot)][ieb_pkg::FLAG_BIT])
    else $error("X empty flag not set after completion");

  bulk_nak_a: assert property (
    s_fire_bulk ##0 cnt[ieb_pkg::FLAG_BIT] |=> rsp_valid_out && rsp_nak_out)
    else $error("Empty bulk buffer not answered with NAK");

  iso_no_nak_a: assert property (
    s_fire_iso |=> rsp_valid_out && !rsp_nak_out)
    else $error("Isochronous endpoint answered with NAK");

  bulk_len_a: assert property (
    s_fire_bulk ##0 !cnt[ieb_pkg::FLAG_BIT]
    |=> rsp_len_out == {5'h00, $past(cnt[6:0])})
    else $error("Bulk length differs from count");

  iso_len_a: assert property (
    s_fire_iso |=> rsp_len_out == {5'h00, $past(cnt[6:0])} * ({7'h00, $past(bytes_per_sample)} + 12'h001))
    else $error("Iso length not samples times size");

  bps_max_a: assert property (
    s_fire_iso ##0 (bytes_per_sample == 5'h1F) |=> rsp_len_out == {$past(cnt[6:0]), 5'h00})
    else $error("Largest sample size is not 32 bytes");

  start_addr_a: assert property (
    s_fire_empty ##0 !ep_bad |=> rsp_addr_out == {$past(base), 3'h0})
    else $error("Start address not base times eight");

  addr_low_a: assert property (
    rsp_valid_out |-> rsp_addr_out[2:0] == 3'h0)
    else $error("Start address low bits not zero");

  stall_hold_a: assert property (
    s_stall |=> rsp_valid_out && $stable(rsp_q))
    else $error("Answer changed while stalled");

  unmapped_rd_a: assert property (
    take && !hwrite_in && !addr_ok |=> hrdata_out == ieb_pkg::RDATA_RESET)
    else $error("Unmapped read returned data");
endmodule
`default_nettype wire
